// File: include/ais_pkg.sv
package ais_pkg;
	// ==========================================
	// register offsets
	localparam logic [15:0] ADDR_FIRST_RANGE = 16'h0410;
	localparam logic [15:0] ADDR_FIRST_GAIN = 16'h0411;
	localparam logic [15:0] ADDR_FIRST_BIAS = 16'h0412;
	localparam logic [15:0] ADDR_OPT_RANGE = 16'h0413;
	localparam logic [15:0] ADDR_OPT_FUNC = 16'h0414;
	localparam logic [15:0] ADDR_OPT_GAIN = 16'h0415;
	localparam logic [15:0] ADDR_OPT_BIAS = 16'h0416;
	localparam logic [15:0] ADDR_SECOND_RANGE = 16'h0417;
	localparam logic [15:0] ADDR_SECOND_FUNC = 16'h0418;
	localparam logic [15:0] ADDR_SECOND_GAIN = 16'h0419;
	localparam logic [15:0] ADDR_SECOND_BIAS = 16'h041A;
	localparam logic [15:0] ADDR_FILTER = 16'h041B;
	localparam logic [15:0] ADDR_SOURCE = 16'h041C;
	// ==========================================
	// reset values and limits
	localparam logic [15:0] RESET_FIRST_RANGE = 16'h0000;
	localparam logic [15:0] RESET_OPT_RANGE = 16'h0000;
	localparam logic [15:0] RESET_OPT_FUNC = 16'h001F;
	localparam logic [15:0] RESET_SECOND_RANGE = 16'h0002;
	localparam logic [15:0] RESET_SECOND_FUNC = 16'h0000;
	localparam logic [15:0] RESET_GAIN = 16'h03E8;
	localparam logic [15:0] RESET_BIAS = 16'h0000;
	localparam logic [15:0] RESET_FILTER = 16'h0003;
	localparam logic [15:0] RESET_SOURCE = 16'h0000;
	localparam logic [15:0] GAIN_MAX = 16'h2710;
	localparam logic signed [15:0] BIAS_MIN = 16'shFC18;
	localparam logic signed [15:0] BIAS_MAX = 16'sh03E8;
	localparam logic [15:0] OPT_FUNC_MAX = 16'h0021;
	localparam logic [15:0] SECOND_FUNC_MAX = 16'h001F;
	localparam logic [15:0] FILTER_MAX = 16'h00C8;
	localparam logic [15:0] SOURCE_MAX = 16'h0001;
	// ==========================================
	// encodings
	localparam logic [1:0] RANGE_UNIPOLAR = 2'h0;
	localparam logic [1:0] RANGE_BIPOLAR = 2'h1;
	localparam logic [1:0] RANGE_CURRENT = 2'h2;
	localparam logic [15:0] RANGE_BIPOLAR_W = 16'h0001;
	localparam logic [15:0] RANGE_CURRENT_W = 16'h0002;
	localparam int unsigned FUNC_W = 6;
	localparam logic [5:0] FUNC_FREQ_BIAS = 6'h00;
	localparam logic [5:0] FUNC_FREQ_GAIN = 6'h01;
	localparam logic [5:0] FUNC_UNUSED = 6'h1F;
	localparam logic SOURCE_FIRST = 1'b0;
	localparam logic SOURCE_SECOND = 1'b1;
	// ==========================================
	// converter scaling
	localparam int unsigned ADC_W = 12;
	localparam int unsigned NORM_W = 13;
	localparam int unsigned FULL_SCALE_SHIFT = 11;
	localparam logic signed [15:0] CURRENT_ZERO = 16'sh019A;
	localparam logic signed [15:0] CURRENT_MUL = 16'sh0005;
	localparam int unsigned CURRENT_SHIFT = 2;
	localparam logic signed [15:0] NORM_MAX = 16'sh07FF;
	localparam logic signed [31:0] OUT_MAX = 32'sh0000_2710;
	localparam logic signed [31:0] OUT_MIN = -32'sh0000_2710;
	localparam logic signed [15:0] FULL_PERCENT = 16'sh03E8;
	// ==========================================
	// filter timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned FILTER_TICK_NS = 1000000;
	localparam int unsigned FILTER_TICK_CYCLES = FILTER_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned FILTER_UNIT_NS = 10000000;
	localparam logic [15:0] TICKS_PER_UNIT = 16'(FILTER_UNIT_NS / FILTER_TICK_NS);
	localparam int unsigned ALPHA_W = 17;
	localparam int unsigned FRAC_W = 16;
	localparam logic [16:0] ALPHA_ONE = 17'h10000;
	localparam logic [4:0] DIV_LAST_STEP = 5'h10;
endpackage

// File: rtl/ais_analog_input_scaling.sv
// Operation
// R1: first input range 0 unipolar, 1 bipolar
// R2: first gain: percent at 10 V, 0..1000.0
// R3: first bias: percent at 0 V, +-100.0
// R4: option range uses same encoding, default 0
// R5: option function codes 0..21, reset 1F
// R6: option gain and bias at 10/0 V
// R7: second range adds 4-20 mA, default 2
// R8: second function codes 0..1F, default 0
// R9: source 1: second selector sets first function
// R10: second gain at 10 V or 20 mA
// R11: second bias at 0 V or 4 mA
// R12: shared lag filter, 0..2.00 s, 0.03
// R13: source 0: first input is main reference
// R14: source 1: second input is main reference
// R15: option settings only with card, mode 0
// R16: code 0 frequency bias, 1 frequency gain
// R17: code 1F drives no function
// R18: linear bias plus gain scaling, clamped
// R19: selectors locked while running; gain, bias free
module ais_analog_input_scaling
#(
	parameter int unsigned TICK_CYCLES = ais_pkg::FILTER_TICK_CYCLES
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWriteData,
	output logic [15:0] regReadData,
	output logic regAck,
	output logic regRefused,
	input wire logic running,
	input wire logic optionCardPresent,
	input wire logic optionCardModeSetting,
	input wire logic signed [11:0] firstAnalogInput,
	input wire logic signed [11:0] secondAnalogInput,
	input wire logic signed [11:0] optionChannelThree,
	output logic signed [15:0] firstInputValue,
	output logic signed [15:0] secondInputValue,
	output logic signed [15:0] optionChannelValue,
	output logic [5:0] firstInputFunction,
	output logic [5:0] secondInputFunction,
	output logic [5:0] optionChannelFunction,
	output logic signed [15:0] mainReference,
	output logic signed [15:0] frequencyBias,
	output logic signed [15:0] frequencyGain,
	output logic referenceSourceDisplay
);
	typedef enum logic {DIV_IDLE, DIV_RUN} ais_div_state_t;

	// ==========================================
	// arithmetic helpers
	function automatic logic signed [15:0] clampOut(input logic signed [31:0] v);
		if (v > ais_pkg::OUT_MAX)
			return 16'(ais_pkg::OUT_MAX);
		else if (v < ais_pkg::OUT_MIN)
			return 16'(ais_pkg::OUT_MIN);
		return 16'(v);
	endfunction

	function automatic logic signed [12:0] normInput(input logic signed [11:0] raw, input logic [1:0] range);
		logic signed [15:0] wide;
		logic signed [15:0] cur;
		wide = 16'(raw);
		cur = ($signed({wide[15:2], 2'b00}) - ais_pkg::CURRENT_ZERO) * ais_pkg::CURRENT_MUL;
		cur = cur >>> ais_pkg::CURRENT_SHIFT;
		case (range)
			ais_pkg::RANGE_BIPOLAR: return 13'(wide); // see R1
			ais_pkg::RANGE_CURRENT: // see R7
			begin
				if (cur < 16'sh0000)
					return 13'sh0000;
				else if (cur > ais_pkg::NORM_MAX)
					return 13'(ais_pkg::NORM_MAX);
				return 13'(cur);
			end
			default: return (wide < 16'sh0000) ? 13'sh0000 : 13'(wide);
		endcase
	endfunction

	function automatic logic signed [15:0] scaleInput(input logic signed [12:0] n, input logic [15:0] gain,
		input logic [15:0] bias);
		logic signed [31:0] prod;
		prod = $signed({16'h0000, gain}) * 32'(n);
		return clampOut(32'($signed(bias)) + (prod >>> ais_pkg::FULL_SCALE_SHIFT)); // see R18
	endfunction

	// ==========================================
	// settings
	logic [15:0] firstRange_reg, firstGain_reg, firstBias_reg;
	logic [15:0] optRange_reg, optFunc_reg, optGain_reg, optBias_reg;
	logic [15:0] secondRange_reg, secondFunc_reg, secondGain_reg, secondBias_reg;
	logic [15:0] filterConst_reg, source_reg;
	logic optionVisible;
	logic writeHit, writeLegal, writeLocked, writeAccept;
	logic [15:0] readNext;
	logic readHit;
	logic signed [15:0] wdSigned;

	assign optionVisible = optionCardPresent && !optionCardModeSetting; // see R15
	assign wdSigned = $signed(regWriteData);

	always_comb
	begin
		writeHit = 1'b1;
		writeLegal = 1'b0;
		writeLocked = 1'b1;
		case (regAddr)
			ais_pkg::ADDR_FIRST_RANGE: writeLegal = regWriteData <= ais_pkg::RANGE_BIPOLAR_W; // see R1
			ais_pkg::ADDR_OPT_RANGE: // see R4
			begin
				writeHit = optionVisible;
				writeLegal = regWriteData <= ais_pkg::RANGE_BIPOLAR_W;
			end
			ais_pkg::ADDR_OPT_FUNC: // see R5
			begin
				writeHit = optionVisible;
				writeLegal = regWriteData <= ais_pkg::OPT_FUNC_MAX;
			end
			ais_pkg::ADDR_SECOND_RANGE: writeLegal = regWriteData <= ais_pkg::RANGE_CURRENT_W; // see R7
			ais_pkg::ADDR_SECOND_FUNC: writeLegal = regWriteData <= ais_pkg::SECOND_FUNC_MAX; // see R8
			ais_pkg::ADDR_FILTER: writeLegal = regWriteData <= ais_pkg::FILTER_MAX; // see R12
			ais_pkg::ADDR_SOURCE: writeLegal = regWriteData <= ais_pkg::SOURCE_MAX;
			ais_pkg::ADDR_FIRST_GAIN, ais_pkg::ADDR_SECOND_GAIN: // see R2 R10
			begin
				writeLocked = 1'b0;
				writeLegal = regWriteData <= ais_pkg::GAIN_MAX;
			end
			ais_pkg::ADDR_FIRST_BIAS, ais_pkg::ADDR_SECOND_BIAS: // see R3 R11
			begin
				writeLocked = 1'b0;
				writeLegal = wdSigned >= ais_pkg::BIAS_MIN && wdSigned <= ais_pkg::BIAS_MAX;
			end
			ais_pkg::ADDR_OPT_GAIN: // see R6
			begin
				writeHit = optionVisible;
				writeLocked = 1'b0;
				writeLegal = regWriteData <= ais_pkg::GAIN_MAX;
			end
			ais_pkg::ADDR_OPT_BIAS: // see R6
			begin
				writeHit = optionVisible;
				writeLocked = 1'b0;
				writeLegal = wdSigned >= ais_pkg::BIAS_MIN && wdSigned <= ais_pkg::BIAS_MAX;
			end
			default: writeHit = 1'b0;
		endcase
		writeAccept = regWrite && writeHit && writeLegal && !(writeLocked && running); // see R19
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			firstRange_reg <= ais_pkg::RESET_FIRST_RANGE;
			firstGain_reg <= ais_pkg::RESET_GAIN;
			firstBias_reg <= ais_pkg::RESET_BIAS;
			optRange_reg <= ais_pkg::RESET_OPT_RANGE;
			optFunc_reg <= ais_pkg::RESET_OPT_FUNC;
			optGain_reg <= ais_pkg::RESET_GAIN;
			optBias_reg <= ais_pkg::RESET_BIAS;
			secondRange_reg <= ais_pkg::RESET_SECOND_RANGE;
			secondFunc_reg <= ais_pkg::RESET_SECOND_FUNC;
			secondGain_reg <= ais_pkg::RESET_GAIN;
			secondBias_reg <= ais_pkg::RESET_BIAS;
			filterConst_reg <= ais_pkg::RESET_FILTER;
			source_reg <= ais_pkg::RESET_SOURCE;
		end
		else if (writeAccept)
		begin
			case (regAddr)
				ais_pkg::ADDR_FIRST_RANGE: firstRange_reg <= regWriteData;
				ais_pkg::ADDR_FIRST_GAIN: firstGain_reg <= regWriteData;
				ais_pkg::ADDR_FIRST_BIAS: firstBias_reg <= regWriteData;
				ais_pkg::ADDR_OPT_RANGE: optRange_reg <= regWriteData;
				ais_pkg::ADDR_OPT_FUNC: optFunc_reg <= regWriteData;
				ais_pkg::ADDR_OPT_GAIN: optGain_reg <= regWriteData;
				ais_pkg::ADDR_OPT_BIAS: optBias_reg <= regWriteData;
				ais_pkg::ADDR_SECOND_RANGE: secondRange_reg <= regWriteData;
				ais_pkg::ADDR_SECOND_FUNC: secondFunc_reg <= regWriteData;
				ais_pkg::ADDR_SECOND_GAIN: secondGain_reg <= regWriteData;
				ais_pkg::ADDR_SECOND_BIAS: secondBias_reg <= regWriteData;
				ais_pkg::ADDR_FILTER: filterConst_reg <= regWriteData;
				ais_pkg::ADDR_SOURCE: source_reg <= regWriteData;
				default: source_reg <= source_reg;
			endcase
		end
	end

	// ==========================================
	// read port and answers
	always_comb
	begin
		readHit = 1'b1;
		case (regAddr)
			ais_pkg::ADDR_FIRST_RANGE: readNext = firstRange_reg;
			ais_pkg::ADDR_FIRST_GAIN: readNext = firstGain_reg;
			ais_pkg::ADDR_FIRST_BIAS: readNext = firstBias_reg;
			ais_pkg::ADDR_OPT_RANGE: readNext = optRange_reg;
			ais_pkg::ADDR_OPT_FUNC: readNext = optFunc_reg;
			ais_pkg::ADDR_OPT_GAIN: readNext = optGain_reg;
			ais_pkg::ADDR_OPT_BIAS: readNext = optBias_reg;
			ais_pkg::ADDR_SECOND_RANGE: readNext = secondRange_reg;
			ais_pkg::ADDR_SECOND_FUNC: readNext = secondFunc_reg;
			ais_pkg::ADDR_SECOND_GAIN: readNext = secondGain_reg;
			ais_pkg::ADDR_SECOND_BIAS: readNext = secondBias_reg;
			ais_pkg::ADDR_FILTER: readNext = filterConst_reg;
			ais_pkg::ADDR_SOURCE: readNext = source_reg;
			default:
			begin
				readNext = 16'h0000;
				readHit = 1'b0;
			end
		endcase
		if (regAddr >= ais_pkg::ADDR_OPT_RANGE && regAddr <= ais_pkg::ADDR_OPT_BIAS && !optionVisible)
		begin
			readNext = 16'h0000; // see R15
			readHit = 1'b0;
		end
	end

	logic [15:0] regReadData_reg;
	logic regAck_reg, regRefused_reg;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			regReadData_reg <= 16'h0000;
			regAck_reg <= 1'b0;
			regRefused_reg <= 1'b0;
		end
		else
		begin
			regAck_reg <= regWrite || regRead;
			regRefused_reg <= (regWrite && !writeAccept) || (!regWrite && regRead && !readHit);
			if (regRead && !regWrite)
				regReadData_reg <= readNext;
		end
	end

	// ==========================================
	// filter tick and coefficient divider
	logic [$clog2(TICK_CYCLES)-1:0] tickCount_reg;
	logic filterTick_reg;
	ais_div_state_t divState_reg;
	logic [4:0] divStep_reg;
	logic [16:0] divRem_reg, divQuot_reg, alpha_reg, remTrial;
	logic [15:0] divisor;
	logic divGe, filterWrite;

	assign filterWrite = writeAccept && regAddr == ais_pkg::ADDR_FILTER;
	assign divisor = 16'(filterConst_reg * ais_pkg::TICKS_PER_UNIT) + 16'h0001;
	assign remTrial = {divRem_reg[15:0], divStep_reg == ais_pkg::DIV_LAST_STEP};
	assign divGe = remTrial >= {1'b0, divisor};

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tickCount_reg <= '0;
			filterTick_reg <= 1'b0;
		end
		else
		begin
			filterTick_reg <= tickCount_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
			if (tickCount_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1))
				tickCount_reg <= '0;
			else
				tickCount_reg <= tickCount_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			divState_reg <= DIV_RUN;
			divStep_reg <= ais_pkg::DIV_LAST_STEP;
			divRem_reg <= 17'h00000;
			divQuot_reg <= 17'h00000;
			alpha_reg <= ais_pkg::ALPHA_ONE;
		end
		else if (filterWrite)
		begin
			divState_reg <= DIV_RUN;
			divStep_reg <= ais_pkg::DIV_LAST_STEP;
			divRem_reg <= 17'h00000;
			divQuot_reg <= 17'h00000;
		end
		else
		begin
			case (divState_reg)
				DIV_RUN: // see R12
				begin
					divRem_reg <= divGe ? remTrial - {1'b0, divisor} : remTrial;
					divQuot_reg <= {divQuot_reg[15:0], divGe};
					divStep_reg <= divStep_reg - 5'h01;
					if (divStep_reg == 5'h00)
					begin
						alpha_reg <= {divQuot_reg[15:0], divGe};
						divState_reg <= DIV_IDLE;
					end
				end
				default: divState_reg <= DIV_IDLE;
			endcase
		end
	end

	// ==========================================
	// conditioning
	logic signed [12:0] firstFilt, secondFilt;

	ais_lag_filter firstFilter
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.sampleTick(filterTick_reg),
		.sampleIn(normInput(firstAnalogInput, firstRange_reg[1:0])),
		.alpha(alpha_reg),
		.filtered(firstFilt)
	);

	ais_lag_filter secondFilter
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.sampleTick(filterTick_reg),
		.sampleIn(normInput(secondAnalogInput, secondRange_reg[1:0])),
		.alpha(alpha_reg),
		.filtered(secondFilt)
	);

	logic signed [15:0] firstNext, secondNext, optNext, biasNext, gainNext;
	logic [5:0] firstFuncNext, secondFuncNext, optFuncNext;

	always_comb
	begin
		firstNext = scaleInput(firstFilt, firstGain_reg, firstBias_reg); // see R2 R3
		secondNext = scaleInput(secondFilt, secondGain_reg, secondBias_reg); // see R10 R11
		optNext = optionVisible ? scaleInput(normInput(optionChannelThree, optRange_reg[1:0]), optGain_reg,
			optBias_reg) : 16'sh0000; // see R6
		firstFuncNext = source_reg[0] ? secondFunc_reg[5:0] : ais_pkg::FUNC_UNUSED; // see R9 R13
		secondFuncNext = source_reg[0] ? ais_pkg::FUNC_UNUSED : secondFunc_reg[5:0]; // see R14
		optFuncNext = optionVisible ? optFunc_reg[5:0] : ais_pkg::FUNC_UNUSED; // see R15
		biasNext = clampOut(32'(firstFuncNext == ais_pkg::FUNC_FREQ_BIAS ? firstNext : 16'sh0000)
			+ 32'(secondFuncNext == ais_pkg::FUNC_FREQ_BIAS ? secondNext : 16'sh0000)
			+ 32'(optFuncNext == ais_pkg::FUNC_FREQ_BIAS ? optNext : 16'sh0000)); // see R16 R17
		if (firstFuncNext == ais_pkg::FUNC_FREQ_GAIN)
			gainNext = firstNext; // see R16
		else if (secondFuncNext == ais_pkg::FUNC_FREQ_GAIN)
			gainNext = secondNext;
		else if (optFuncNext == ais_pkg::FUNC_FREQ_GAIN)
			gainNext = optNext;
		else
			gainNext = ais_pkg::FULL_PERCENT;
	end

	logic signed [15:0] firstValue_reg, secondValue_reg, optValue_reg, mainRef_reg, bias_reg, gain_reg;
	logic [5:0] firstFunc_reg, secondFuncOut_reg, optFuncOut_reg;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			firstValue_reg <= 16'sh0000;
			secondValue_reg <= 16'sh0000;
			optValue_reg <= 16'sh0000;
			mainRef_reg <= 16'sh0000;
			bias_reg <= 16'sh0000;
			gain_reg <= ais_pkg::FULL_PERCENT;
			firstFunc_reg <= ais_pkg::FUNC_UNUSED;
			secondFuncOut_reg <= ais_pkg::FUNC_UNUSED;
			optFuncOut_reg <= ais_pkg::FUNC_UNUSED;
		end
		else
		begin
			firstValue_reg <= firstNext;
			secondValue_reg <= secondNext;
			optValue_reg <= optNext;
			mainRef_reg <= source_reg[0] ? secondNext : firstNext; // see R13 R14
			bias_reg <= biasNext;
			gain_reg <= gainNext;
			firstFunc_reg <= firstFuncNext;
			secondFuncOut_reg <= secondFuncNext;
			optFuncOut_reg <= optFuncNext;
		end
	end

	assign regReadData = regReadData_reg;
	assign regAck = regAck_reg;
	assign regRefused = regRefused_reg;
	assign firstInputValue = firstValue_reg;
	assign secondInputValue = secondValue_reg;
	assign optionChannelValue = optValue_reg;
	assign firstInputFunction = firstFunc_reg;
	assign secondInputFunction = secondFuncOut_reg;
	assign optionChannelFunction = optFuncOut_reg;
	assign mainReference = mainRef_reg;
	assign frequencyBias = bias_reg;
	assign frequencyGain = gain_reg;
	assign referenceSourceDisplay = source_reg[0];

	// ==========================================
	// checks
	a_locked_range: assert property (@(posedge clk_sys) disable iff (!reset_n) // see R19
		regWrite && running && regAddr == ais_pkg::ADDR_FIRST_RANGE |=> regRefused && $stable(firstRange_reg))
		else $error("range write taken while running");
	a_gain_taken: assert property (@(posedge clk_sys) disable iff (!reset_n) // see R2
		regWrite && regAddr == ais_pkg::ADDR_FIRST_GAIN && regWriteData <= ais_pkg::GAIN_MAX
		|=> !regRefused && firstGain_reg == $past(regWriteData))
		else $error("gain write lost");
	a_range_reject: assert property (@(posedge clk_sys) disable iff (!reset_n) // see R7
		regWrite && regAddr == ais_pkg::ADDR_SECOND_RANGE && regWriteData > ais_pkg::RANGE_CURRENT_W
		|=> regRefused && $stable(secondRange_reg))
		else $error("illegal range code stored");
	a_option_hidden: assert property (@(posedge clk_sys) disable iff (!reset_n) // see R15
		!(optionCardPresent && !optionCardModeSetting) |=> optionChannelFunction == ais_pkg::FUNC_UNUSED
		&& optionChannelValue == 16'sh0000)
		else $error("hidden option channel active");
	a_main_first: assert property (@(posedge clk_sys) disable iff (!reset_n) // see R13
		source_reg == ais_pkg::RESET_SOURCE |=> mainReference == firstInputValue)
		else $error("main reference not from first input");
	a_main_second: assert property (@(posedge clk_sys) disable iff (!reset_n) // see R14
		source_reg[0] == ais_pkg::SOURCE_SECOND |=> mainReference == secondInputValue
		&& firstInputFunction == $past(secondFunc_reg[5:0]))
		else $error("second source routing wrong");
	a_unused_bias: assert property (@(posedge clk_sys) disable iff (!reset_n) // see R17
		firstFuncNext != ais_pkg::FUNC_FREQ_BIAS && secondFuncNext != ais_pkg::FUNC_FREQ_BIAS
		&& optFuncNext != ais_pkg::FUNC_FREQ_BIAS |=> frequencyBias == 16'sh0000)
		else $error("bias driven by no channel");
	a_zero_input: assert property (@(posedge clk_sys) disable iff (!reset_n) // see R18
		firstFilt == 13'sh0000 |=> firstInputValue == $past(firstBias_reg))
		else $error("zero input does not give bias");
	a_divide_ends: assert property (@(posedge clk_sys) disable iff (!reset_n) // see R12
		$rose(divState_reg == DIV_RUN) |-> ##[17:18] divState_reg == DIV_IDLE)
		else $error("filter coefficient not ready");
endmodule // ais_analog_input_scaling

// File: rtl/ais_lag_filter.sv
module ais_lag_filter
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic sampleTick,
	input wire logic signed [12:0] sampleIn,
	input wire logic [16:0] alpha,
	output logic signed [12:0] filtered
);
	// ==========================================
	// first-order lag, 16 fraction bits
	logic signed [28:0] acc_reg;
	logic signed [29:0] diff;
	logic signed [47:0] step;

	always_comb
	begin
		diff = {sampleIn[12], sampleIn, 16'h0000} - {acc_reg[28], acc_reg};
		step = 48'(diff) * $signed({31'h0000_0000, alpha});
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			acc_reg <= 29'sh0000_0000;
		else if (sampleTick)
			acc_reg <= acc_reg + 29'(step >>> ais_pkg::FRAC_W); // see R12
	end

	assign filtered = acc_reg[28:16];
endmodule // ais_lag_filter

// File: test/ais_analog_source.sv
module ais_analog_source
(
	input wire logic clk_sys,
	input wire logic signed [11:0] firstLevel,
	input wire logic signed [11:0] secondLevel,
	input wire logic signed [11:0] thirdLevel,
	output logic signed [11:0] firstCode,
	output logic signed [11:0] secondCode,
	output logic signed [11:0] thirdCode
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// converter codes refresh every clock
	always_ff @(posedge clk_sys)
	begin
		firstCode <= firstLevel;
		secondCode <= secondLevel;
		thirdCode <= thirdLevel;
	end
endmodule // ais_analog_source

// File: test/analog_input_scaling_tb.sv
module analog_input_scaling_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [15:0] regAddr = 16'h0000;
	logic [15:0] regWriteData = 16'h0000;
	logic running = 1'b0;
	logic optionCardPresent = 1'b1;
	logic optionCardModeSetting = 1'b0;
	logic signed [11:0] lvl1 = 12'h000;
	logic signed [11:0] lvl2 = 12'h000;
	logic signed [11:0] lvl3 = 12'h000;
	logic signed [11:0] code1, code2, code3;
	logic [15:0] regReadData;
	logic regAck, regRefused, referenceSourceDisplay;
	logic signed [15:0] firstInputValue, secondInputValue, optionChannelValue;
	logic signed [15:0] mainReference, frequencyBias, frequencyGain;
	logic [5:0] firstInputFunction, secondInputFunction, optionChannelFunction;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [15:0] rstVal [13] = '{16'h0000, 16'h03E8, 16'h0000, 16'h0000, 16'h001F, 16'h03E8, 16'h0000,
		16'h0002, 16'h0000, 16'h03E8, 16'h0000, 16'h0003, 16'h0000};
	logic [15:0] badAddr [8] = '{16'h0410, 16'h0411, 16'h0412, 16'h0414, 16'h0418, 16'h0417, 16'h041B, 16'h041C};
	logic [15:0] badData [8] = '{16'h0002, 16'h2711, 16'h03E9, 16'h0022, 16'h0020, 16'h0003, 16'h00C9, 16'h0002};
	ais_analog_source ais_analog_source_i (.clk_sys(clk_sys), .firstLevel(lvl1), .secondLevel(lvl2),
		.thirdLevel(lvl3), .firstCode(code1), .secondCode(code2), .thirdCode(code3));
	ais_analog_input_scaling #(.TICK_CYCLES(8)) ais_analog_input_scaling_i (.clk_sys(clk_sys), .reset_n(reset_n),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
		.regReadData(regReadData), .regAck(regAck), .regRefused(regRefused), .running(running),
		.optionCardPresent(optionCardPresent), .optionCardModeSetting(optionCardModeSetting),
		.firstAnalogInput(code1), .secondAnalogInput(code2), .optionChannelThree(code3),
		.firstInputValue(firstInputValue), .secondInputValue(secondInputValue),
		.optionChannelValue(optionChannelValue), .firstInputFunction(firstInputFunction),
		.secondInputFunction(secondInputFunction), .optionChannelFunction(optionChannelFunction),
		.mainReference(mainReference), .frequencyBias(frequencyBias), .frequencyGain(frequencyGain),
		.referenceSourceDisplay(referenceSourceDisplay));
	// ==========================================
	// clock and hang guard
	initial
	begin
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			wrap_up();
		end
	end
	// ==========================================
	// access and compare tasks
	task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
		comparisons++;
		if (got !== expv)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, expv, got);
		end
	endtask
	task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data, input logic refused);
		@(posedge clk_sys);
		#1;
		regWrite = wr;
		regRead = !wr;
		regAddr = addr;
		regWriteData = data;
		@(posedge clk_sys);
		#1;
		regWrite = 1'b0;
		regRead = 1'b0;
		chk("ack", 16'h0001, {15'h0000, regAck});
		chk("refused", {15'h0000, refused}, {15'h0000, regRefused});
	endtask
	task automatic rd(input logic [15:0] addr, input logic [15:0] expv, input logic refused);
		access(1'b0, addr, 16'h0000, refused);
		chk("read data", expv, regReadData);
	endtask
	task automatic settle();
		repeat (100) @(posedge clk_sys);
		#1;
	endtask
	task automatic wrap_up();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		repeat (5) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		for (int i = 0; i < 13; i++)
			rd(16'h0410 + 16'(i), rstVal[i], 1'b0);
		for (int i = 0; i < 8; i++)
			access(1'b1, badAddr[i], badData[i], 1'b1);
		access(1'b1, 16'h0412, 16'hFC18, 1'b0);
		rd(16'h0412, 16'hFC18, 1'b0);
		access(1'b1, 16'h0412, 16'h0000, 1'b0);
		access(1'b1, 16'h0414, 16'h0021, 1'b0);
		rd(16'h0414, 16'h0021, 1'b0);
		access(1'b1, 16'h0414, 16'h001F, 1'b0);
		running = 1'b1;
		access(1'b1, 16'h0410, 16'h0001, 1'b1);
		access(1'b1, 16'h041B, 16'h0000, 1'b1);
		access(1'b1, 16'h0411, 16'h07D0, 1'b0);
		rd(16'h0411, 16'h07D0, 1'b0);
		running = 1'b0;
		optionCardModeSetting = 1'b1;
		rd(16'h0415, 16'h0000, 1'b1);
		access(1'b1, 16'h0415, 16'h0001, 1'b1);
		optionCardModeSetting = 1'b0;
		rd(16'h0415, 16'h03E8, 1'b0);
		optionCardPresent = 1'b0;
		rd(16'h0413, 16'h0000, 1'b1);
		optionCardPresent = 1'b1;
		rd(16'h0400, 16'h0000, 1'b1);
		access(1'b1, 16'h041B, 16'h0000, 1'b0);
		lvl2 = 12'sd2047;
		settle();
		chk("current full", 16'h03E5, secondInputValue);
		lvl2 = 12'sd410;
		settle();
		chk("current zero", 16'h0000, secondInputValue);
		access(1'b1, 16'h0410, 16'h0001, 1'b0);
		access(1'b1, 16'h0417, 16'h0001, 1'b0);
		lvl1 = -12'sd1024;
		lvl2 = 12'sd1024;
		lvl3 = 12'sd1024;
		settle();
		chk("first value", 16'hFC18, firstInputValue);
		chk("second value", 16'h01F4, secondInputValue);
		chk("option value", 16'h01F4, optionChannelValue);
		chk("main reference", 16'hFC18, mainReference);
		chk("bias sum", 16'h01F4, frequencyBias);
		chk("gain idle", 16'h03E8, frequencyGain);
		chk("option function", 16'h001F, {10'h000, optionChannelFunction});
		chk("second function", 16'h0000, {10'h000, secondInputFunction});
		access(1'b1, 16'h041C, 16'h0001, 1'b0);
		settle();
		chk("main reference", 16'h01F4, mainReference);
		chk("first function", 16'h0000, {10'h000, firstInputFunction});
		chk("bias sum", 16'hFC18, frequencyBias);
		chk("source shown", 16'h0001, {15'h0000, referenceSourceDisplay});
		chk("second function", 16'h001F, {10'h000, secondInputFunction});
		access(1'b1, 16'h0418, 16'h0001, 1'b0);
		settle();
		chk("gain path", 16'hFC18, frequencyGain);
		chk("bias none", 16'h0000, frequencyBias);
		access(1'b1, 16'h041C, 16'h0000, 1'b0);
		access(1'b1, 16'h0410, 16'h0000, 1'b0);
		settle();
		chk("unipolar clamp", 16'h0000, firstInputValue);
		chk("main reference", 16'h0000, mainReference);
		wrap_up();
	end
endmodule // analog_input_scaling_tb
